// ===== src/cal_regs_map.vh
`ifndef CAL_REGS_MAP_VH
`define CAL_REGS_MAP_VH

// Register indices on the configuration serial port.
`define ADDR_CH2_RES 15'h000B
`define ADDR_CH1_RES 15'h000C
`define ADDR_CAL_CFG 15'h000D
`define ADDR_CMP_OFS 15'h000E

// Channel set-resistor register fields.
`define RES_EN_BIT 15
`define RES_CAL_HI 12
`define RES_CAL_LO 8
`define RES_SET_HI 4
`define RES_SET_LO 0
`define RES_SET_RST 5'h0A

// Calibration configuration register fields.
`define CFG_OFS_OF_BIT 14
`define CFG_OFS_UF_BIT 13
`define CFG_RES_OF_BIT 12
`define CFG_RES_UF_BIT 11
`define CFG_GAIN_OF_BIT 10
`define CFG_GAIN_UF_BIT 9
`define CFG_CAL_RST_BIT 8
`define CFG_CAL_MODE_BIT 7
`define CFG_MODE_EN_BIT 6
`define CFG_RNG_HI 5
`define CFG_RNG_LO 4
`define CFG_CLK_EN_BIT 3
`define CFG_DIV_HI 2
`define CFG_DIV_LO 0

// Comparator offset register fields.
`define OFS_RES_HI 14
`define OFS_RES_LO 8
`define OFS_DONE_BIT 1
`define OFS_START_BIT 0

// Serial frame: one direction bit, fifteen address bits, sixteen data bits.
`define SPI_FRAME_BITS 6'h20
`define SPI_HDR_BITS 6'h10

`endif

// ===== src/cal_spi_port.v
`include "cal_regs_map.vh"

module cal_spi_port
(
    input wire clk, // converter clock
    input wire rst_n, // asynchronous reset, active low
    input wire spi_sclk, // serial clock, sampled
    input wire spi_cs_n, // chip select, active low
    input wire spi_sdi, // serial data in
    input wire [15:0] rd_data, // read data for rd_addr
    output reg spi_sdo, // serial data out
    output reg spi_sdo_oe, // serial data out enable
    output reg [14:0] rd_addr, // address being accessed
    output reg wr_pulse, // one-cycle write strobe
    output reg [15:0] wr_data // write data
);
    reg sclk_d_r;
    reg [5:0] cnt_r;
    reg [15:0] sh_r;
    reg [15:0] out_r;
    reg rd_r;
    wire rise;
    wire fall;

    assign rise = spi_sclk & ~sclk_d_r;
    assign fall = ~spi_sclk & sclk_d_r;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d_r <= 1'b0;
            cnt_r <= 6'h00;
            sh_r <= 16'h0000;
            out_r <= 16'h0000;
            rd_r <= 1'b0;
            rd_addr <= 15'h0000;
            wr_pulse <= 1'b0;
            wr_data <= 16'h0000;
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end
        else
        begin
            sclk_d_r <= spi_sclk;
            wr_pulse <= 1'b0;
            if (spi_cs_n)
            begin
                cnt_r <= 6'h00;
                spi_sdo_oe <= 1'b0;
            end
            else
            begin
                if (rise && cnt_r != `SPI_FRAME_BITS)
                begin
                    sh_r <= {sh_r[14:0], spi_sdi};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == `SPI_HDR_BITS - 6'h01)
                    begin
                        rd_r <= sh_r[14];
                        rd_addr <= {sh_r[13:0], spi_sdi};
                    end
                    if (cnt_r == `SPI_FRAME_BITS - 6'h01 && !rd_r)
                    begin
                        wr_data <= {sh_r[14:0], spi_sdi};
                        wr_pulse <= 1'b1;
                    end
                end
                // Read data is captured on the first serial clock fall after the address so the decode has settled.
                if (cnt_r == `SPI_HDR_BITS && rd_r && !rise)
                begin
                    if (fall)
                    begin
                        spi_sdo <= rd_data[15];
                        out_r <= {rd_data[14:0], 1'b0};
                        spi_sdo_oe <= 1'b1;
                    end
                end
                else if (fall && rd_r && cnt_r > `SPI_HDR_BITS && cnt_r < `SPI_FRAME_BITS)
                begin
                    spi_sdo <= out_r[15];
                    out_r <= {out_r[14:0], 1'b0};
                end
                if (cnt_r == `SPI_FRAME_BITS)
                    spi_sdo_oe <= 1'b0;
            end
        end
    end
endmodule

// ===== src/cal_sar.v
module cal_sar
(
    input wire clk, // converter clock
    input wire rst_n, // asynchronous reset, active low
    input wire start, // begin a search
    input wire wide, // 1: seven-bit search, 0: five-bit search
    input wire tick, // calibration clock tick
    input wire cmp_high, // trial value is above target
    output reg busy, // search in progress
    output reg done, // one-cycle pulse at end of search
    output reg [6:0] trial // trial code, final result after done
);
    reg [6:0] mask_r;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            trial <= 7'h00;
            mask_r <= 7'h00;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                busy <= 1'b1;
                mask_r <= wide ? 7'h40 : 7'h10;
                trial <= wide ? 7'h40 : 7'h10;
            end
            else if (busy && tick)
            begin
                // Decide the current bit, then try the next lower one.
                trial <= (cmp_high ? (trial & ~mask_r) : trial) | (mask_r >> 1);
                mask_r <= mask_r >> 1;
                if (mask_r == 7'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== src/dac_calibration_control_regs.v
`include "cal_regs_map.vh"

module dac_calibration_control_regs
(
    input wire clk, // converter clock, 125 MHz
    input wire rst_n, // asynchronous reset, active low
    input wire spi_sclk, // serial clock
    input wire spi_cs_n, // serial chip select, active low
    input wire spi_sdi, // serial data in
    input wire cal_cmp_high, // analog comparator: trial above target
    output wire spi_sdo, // serial data out
    output wire spi_sdo_oe, // serial data out enable
    output reg [4:0] ch1_resistor_code, // resistor code applied to channel 1
    output reg [4:0] ch2_resistor_code, // resistor code applied to channel 2
    output reg ch1_internal_resistor_enable, // channel 1 internal resistor select
    output reg ch2_internal_resistor_enable, // channel 2 internal resistor select
    output reg [6:0] gain_cal_code, // calibrated gain code
    output reg [6:0] offset_cal_code, // calibrated comparator offset
    output reg [1:0] offset_calibration_range, // offset calibration range
    output reg [6:0] cal_trial_code, // trial code to the analog under test
    output reg [2:0] cal_phase, // which quantity is being calibrated
    output reg cal_tick // divided calibration clock pulse
);
    localparam ST_IDLE = 3'd0;
    localparam ST_OFFS = 3'd1;
    localparam ST_RES1 = 3'd2;
    localparam ST_RES2 = 3'd3;
    localparam ST_GAIN = 3'd4;

    reg [4:0] ch1_resistor_setting_r;
    reg [4:0] ch2_resistor_setting_r;
    reg [4:0] ch1_resistor_calibrated_value_r;
    reg [4:0] ch2_resistor_calibrated_value_r;
    reg [6:0] gain_cal_r;
    reg [6:0] ofs_cal_r;
    reg offset_cal_overflow_r;
    reg offset_cal_underflow_r;
    reg resistor_cal_overflow_r;
    reg resistor_cal_underflow_r;
    reg gain_cal_overflow_r;
    reg gain_cal_underflow_r;
    reg cal_rst_bit_r;
    reg mode_en_r;
    reg clk_en_r;
    reg [2:0] div_r;
    reg [6:0] div_cnt_r;
    reg start_r;
    reg calibration_done_r;
    reg have_results_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg sar_start_r;
    reg [15:0] rd_data;
    wire [14:0] addr;
    wire wr_pulse;
    wire [15:0] wr_data;
    wire sar_busy;
    wire sar_done;
    wire [6:0] sar_trial;
    wire cal_mode;
    wire cal_clear;
    wire start_req;
    wire tick_nxt;
    wire [6:0] div_mask;

    function is_full;
        input [6:0] v;
        input wide;
        begin
            is_full = wide ? (v == 7'h7F) : (v[4:0] == 5'h1F);
        end
    endfunction

    function is_zero;
        input [6:0] v;
        input wide;
        begin
            is_zero = wide ? (v == 7'h00) : (v[4:0] == 5'h00);
        end
    endfunction

    cal_spi_port u_spi
    (
        .clk(clk),
        .rst_n(rst_n),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .rd_data(rd_data),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .rd_addr(addr),
        .wr_pulse(wr_pulse),
        .wr_data(wr_data)
    );

    cal_sar u_sar
    (
        .clk(clk),
        .rst_n(rst_n),
        .start(sar_start_r),
        .wide(state_r == ST_OFFS || state_r == ST_GAIN),
        .tick(cal_tick),
        .cmp_high(cal_cmp_high),
        .busy(sar_busy),
        .done(sar_done),
        .trial(sar_trial)
    );

    // Calibrated values count as applied only once a run has produced them.
    assign cal_mode = mode_en_r & have_results_r;
    assign cal_clear = cal_rst_bit_r & wr_pulse & (addr == `ADDR_CAL_CFG)
                       & ~wr_data[`CFG_CAL_RST_BIT];
    assign start_req = wr_pulse & (addr == `ADDR_CMP_OFS) & wr_data[`OFS_START_BIT]
                       & ~start_r;
    assign div_mask = 7'h7F >> (3'd7 - div_r);
    assign tick_nxt = clk_en_r & ((div_cnt_r & div_mask) == div_mask);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_r <= 7'h00;
            cal_tick <= 1'b0;
        end
        else
        begin
            // The counter is cleared while disabled so the first tick after enable is a full period.
            div_cnt_r <= clk_en_r ? div_cnt_r + 7'h01 : 7'h00;
            cal_tick <= tick_nxt;
        end
    end

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (start_req)
                    state_nxt = ST_OFFS;
            ST_OFFS:
                if (sar_done)
                    state_nxt = ST_RES1;
            ST_RES1:
                if (sar_done)
                    state_nxt = ST_RES2;
            ST_RES2:
                if (sar_done)
                    state_nxt = mode_en_r ? ST_GAIN : ST_IDLE;
            ST_GAIN:
                if (sar_done)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch1_resistor_setting_r <= `RES_SET_RST;
            ch2_resistor_setting_r <= `RES_SET_RST;
            ch1_internal_resistor_enable <= 1'b0;
            ch2_internal_resistor_enable <= 1'b0;
            offset_calibration_range <= 2'h0;
            cal_rst_bit_r <= 1'b0;
            mode_en_r <= 1'b0;
            clk_en_r <= 1'b0;
            div_r <= 3'h0;
            start_r <= 1'b0;
        end
        else if (wr_pulse)
        begin
            case (addr)
                `ADDR_CH1_RES:
                begin
                    ch1_internal_resistor_enable <= wr_data[`RES_EN_BIT];
                    ch1_resistor_setting_r <= wr_data[`RES_SET_HI:`RES_SET_LO];
                end
                `ADDR_CH2_RES:
                begin
                    ch2_internal_resistor_enable <= wr_data[`RES_EN_BIT];
                    ch2_resistor_setting_r <= wr_data[`RES_SET_HI:`RES_SET_LO];
                end
                `ADDR_CAL_CFG:
                begin
                    cal_rst_bit_r <= wr_data[`CFG_CAL_RST_BIT];
                    mode_en_r <= wr_data[`CFG_MODE_EN_BIT];
                    offset_calibration_range <= wr_data[`CFG_RNG_HI:`CFG_RNG_LO];
                    clk_en_r <= wr_data[`CFG_CLK_EN_BIT];
                    div_r <= wr_data[`CFG_DIV_HI:`CFG_DIV_LO];
                end
                `ADDR_CMP_OFS:
                    start_r <= wr_data[`OFS_START_BIT];
                default:
                    start_r <= start_r;
            endcase
        end
    end

    // Results: a finishing search sets its values even if a clear lands in the same cycle.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            sar_start_r <= 1'b0;
            ch1_resistor_calibrated_value_r <= 5'h00;
            ch2_resistor_calibrated_value_r <= 5'h00;
            gain_cal_r <= 7'h00;
            ofs_cal_r <= 7'h00;
            offset_cal_overflow_r <= 1'b0;
            offset_cal_underflow_r <= 1'b0;
            resistor_cal_overflow_r <= 1'b0;
            resistor_cal_underflow_r <= 1'b0;
            gain_cal_overflow_r <= 1'b0;
            gain_cal_underflow_r <= 1'b0;
            calibration_done_r <= 1'b0;
            have_results_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sar_start_r <= (state_nxt != ST_IDLE) && (state_nxt != state_r);
            if (cal_clear)
            begin
                ch1_resistor_calibrated_value_r <= 5'h00;
                ch2_resistor_calibrated_value_r <= 5'h00;
                gain_cal_r <= 7'h00;
                ofs_cal_r <= 7'h00;
                offset_cal_overflow_r <= 1'b0;
                offset_cal_underflow_r <= 1'b0;
                resistor_cal_overflow_r <= 1'b0;
                resistor_cal_underflow_r <= 1'b0;
                gain_cal_overflow_r <= 1'b0;
                gain_cal_underflow_r <= 1'b0;
                calibration_done_r <= 1'b0;
                have_results_r <= 1'b0;
            end
            if (start_req && state_r == ST_IDLE)
                calibration_done_r <= 1'b0;
            if (sar_done)
            begin
                case (state_r)
                    ST_OFFS:
                    begin
                        ofs_cal_r <= sar_trial;
                        offset_cal_overflow_r <= is_full(sar_trial, 1'b1);
                        offset_cal_underflow_r <= is_zero(sar_trial, 1'b1);
                    end
                    ST_RES1:
                    begin
                        ch1_resistor_calibrated_value_r <= sar_trial[4:0];
                        resistor_cal_overflow_r <= is_full(sar_trial, 1'b0);
                        resistor_cal_underflow_r <= is_zero(sar_trial, 1'b0);
                    end
                    ST_RES2:
                    begin
                        ch2_resistor_calibrated_value_r <= sar_trial[4:0];
                        resistor_cal_overflow_r <= resistor_cal_overflow_r
                                                   | is_full(sar_trial, 1'b0);
                        resistor_cal_underflow_r <= resistor_cal_underflow_r
                                                    | is_zero(sar_trial, 1'b0);
                    end
                    ST_GAIN:
                    begin
                        gain_cal_r <= sar_trial;
                        gain_cal_overflow_r <= is_full(sar_trial, 1'b1);
                        gain_cal_underflow_r <= is_zero(sar_trial, 1'b1);
                    end
                    default:
                        ofs_cal_r <= ofs_cal_r;
                endcase
                if (state_nxt == ST_IDLE)
                begin
                    calibration_done_r <= 1'b1;
                    have_results_r <= 1'b1;
                end
            end
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch1_resistor_code <= `RES_SET_RST;
            ch2_resistor_code <= `RES_SET_RST;
            gain_cal_code <= 7'h00;
            offset_cal_code <= 7'h00;
            cal_trial_code <= 7'h00;
            cal_phase <= ST_IDLE;
        end
        else
        begin
            ch1_resistor_code <= cal_mode ? ch1_resistor_calibrated_value_r
                                          : ch1_resistor_setting_r;
            ch2_resistor_code <= cal_mode ? ch2_resistor_calibrated_value_r
                                          : ch2_resistor_setting_r;
            gain_cal_code <= gain_cal_r;
            offset_cal_code <= ofs_cal_r;
            cal_trial_code <= sar_busy ? sar_trial : 7'h00;
            cal_phase <= state_r;
        end
    end

    always @*
    begin
        rd_data = 16'h0000;
        case (addr)
            `ADDR_CH1_RES:
            begin
                rd_data[`RES_EN_BIT] = ch1_internal_resistor_enable;
                rd_data[`RES_CAL_HI:`RES_CAL_LO] = ch1_resistor_calibrated_value_r;
                rd_data[`RES_SET_HI:`RES_SET_LO] = ch1_resistor_setting_r;
            end
            `ADDR_CH2_RES:
            begin
                rd_data[`RES_EN_BIT] = ch2_internal_resistor_enable;
                rd_data[`RES_CAL_HI:`RES_CAL_LO] = ch2_resistor_calibrated_value_r;
                rd_data[`RES_SET_HI:`RES_SET_LO] = ch2_resistor_setting_r;
            end
            `ADDR_CAL_CFG:
            begin
                rd_data[`CFG_OFS_OF_BIT] = offset_cal_overflow_r;
                rd_data[`CFG_OFS_UF_BIT] = offset_cal_underflow_r;
                rd_data[`CFG_RES_OF_BIT] = resistor_cal_overflow_r;
                rd_data[`CFG_RES_UF_BIT] = resistor_cal_underflow_r;
                rd_data[`CFG_GAIN_OF_BIT] = gain_cal_overflow_r;
                rd_data[`CFG_GAIN_UF_BIT] = gain_cal_underflow_r;
                rd_data[`CFG_CAL_RST_BIT] = cal_rst_bit_r;
                rd_data[`CFG_CAL_MODE_BIT] = cal_mode;
                rd_data[`CFG_MODE_EN_BIT] = mode_en_r;
                rd_data[`CFG_RNG_HI:`CFG_RNG_LO] = offset_calibration_range;
                rd_data[`CFG_CLK_EN_BIT] = clk_en_r;
                rd_data[`CFG_DIV_HI:`CFG_DIV_LO] = div_r;
            end
            `ADDR_CMP_OFS:
            begin
                rd_data[`OFS_RES_HI:`OFS_RES_LO] = ofs_cal_r;
                rd_data[`OFS_DONE_BIT] = calibration_done_r;
                rd_data[`OFS_START_BIT] = start_r;
            end
            default:
                rd_data = 16'h0000;
        endcase
    end
endmodule

// ===== test/cal_regs_checker_asserts.sv
module cal_regs_checker
(
    input wire logic clk, // converter clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic spi_sclk, // serial clock
    input wire logic spi_cs_n, // serial chip select, active low
    input wire logic spi_sdo, // serial data out
    input wire logic spi_sdo_oe, // serial data out enable
    input wire logic [4:0] ch1_resistor_code, // applied channel 1 code
    input wire logic [4:0] ch2_resistor_code, // applied channel 2 code
    input wire logic [6:0] gain_cal_code, // stored gain result
    input wire logic [6:0] offset_cal_code, // stored offset result
    input wire logic [6:0] cal_trial_code, // search trial code
    input wire logic [2:0] cal_phase, // calibration phase
    input wire logic cal_tick // divided calibration clock pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RESET_CODES: assert property ($rose(rst_n) |-> ch1_resistor_code == 5'h0A
        && ch2_resistor_code == 5'h0A && gain_cal_code == 7'h00 && offset_cal_code == 7'h00)
        else $error("codes wrong after reset");
    AST_PHASE_RANGE: assert property (cal_phase <= 3'h4)
        else $error("calibration phase out of range");
    AST_PHASE_ORDER: assert property ($changed(cal_phase) && cal_phase != 3'h0
        |-> cal_phase == $past(cal_phase) + 3'h1)
        else $error("calibration phase skipped or went back");
    AST_PHASE_ON_TICK: assert property ($changed(cal_phase) && $past(cal_phase) != 3'h0
        && cal_phase != 3'h0 |-> $past(cal_tick, 3))
        else $error("phase advanced without a calibration tick");
    // Loading the first trial of a phase starts from zero and needs no tick.
    AST_TRIAL_ON_TICK: assert property ($changed(cal_trial_code) && cal_phase != 3'h0
        && $past(cal_phase) != 3'h0 && $past(cal_trial_code) != 7'h00
        |-> $past(cal_tick) || $past(cal_tick, 2))
        else $error("trial code moved without a calibration tick");
    AST_IDLE_TRIAL: assert property (cal_phase == 3'h0 && $past(cal_phase) == 3'h0
        |-> cal_trial_code == 7'h00)
        else $error("trial code driven while idle");
    AST_SDO_OFF: assert property (spi_cs_n && $past(spi_cs_n, 3) |-> !spi_sdo_oe)
        else $error("data out driven while deselected");
    AST_SDO_SCLK_LOW: assert property ($changed(spi_sdo) && spi_sdo_oe |-> !spi_sclk)
        else $error("data out changed while serial clock high");
endmodule

bind dac_calibration_control_regs cal_regs_checker u_chk (.clk(clk), .rst_n(rst_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .ch1_resistor_code(ch1_resistor_code), .ch2_resistor_code(ch2_resistor_code),
    .gain_cal_code(gain_cal_code), .offset_cal_code(offset_cal_code),
    .cal_trial_code(cal_trial_code), .cal_phase(cal_phase), .cal_tick(cal_tick));

// ===== test/test_dac_calibration_control_regs.sv
`include "cal_regs_map.vh"

module test_dac_calibration_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, spi_sclk = 0, spi_cs_n = 1, spi_sdi = 0, cal_cmp_high = 0;
    wire spi_sdo, spi_sdo_oe, ch1_internal_resistor_enable, ch2_internal_resistor_enable;
    wire cal_tick;
    wire [4:0] ch1_resistor_code, ch2_resistor_code;
    wire [6:0] gain_cal_code, offset_cal_code, cal_trial_code;
    wire [1:0] offset_calibration_range;
    wire [2:0] cal_phase;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] rd;

    always #4 clk = ~clk;

    dac_calibration_control_regs dut (.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .cal_cmp_high(cal_cmp_high),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ch1_resistor_code(ch1_resistor_code),
        .ch2_resistor_code(ch2_resistor_code),
        .ch1_internal_resistor_enable(ch1_internal_resistor_enable),
        .ch2_internal_resistor_enable(ch2_internal_resistor_enable),
        .gain_cal_code(gain_cal_code), .offset_cal_code(offset_cal_code),
        .offset_calibration_range(offset_calibration_range), .cal_trial_code(cal_trial_code),
        .cal_phase(cal_phase), .cal_tick(cal_tick));

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Each serial clock half lasts four converter clocks, so the sampler always sees it.
    task xfer(input logic rnw, input logic [14:0] addr, input logic [15:0] wd,
              output logic [15:0] rdv);
        logic [31:0] f;
        f = {rnw, addr, wd};
        rdv = 16'h0000;
        spi_cs_n = 0;
        step(4);
        for (int i = 31; i >= 0; i--)
        begin
            spi_sdi = f[i];
            spi_sclk = 0;
            step(4);
            if (i < 16)
                rdv[i] = spi_sdo;
            spi_sclk = 1;
            step(4);
        end
        spi_sclk = 0;
        step(6);
        spi_cs_n = 1;
        spi_sdi = ~spi_sdi;
        step(4);
    endtask

    task wr(input logic [14:0] addr, input logic [15:0] wd);
        logic [15:0] dummy;
        xfer(1'b0, addr, wd, dummy);
    endtask

    task rdchk(input logic [14:0] addr, input logic [15:0] exp, input string what);
        xfer(1'b1, addr, 16'h0000, rd);
        chk(what, exp, rd);
    endtask

    // Polls the completion flag under a bounded number of reads; rd keeps the last value.
    task wait_done();
        for (int k = 0; k < 6; k++)
        begin
            xfer(1'b1, `ADDR_CMP_OFS, 16'h0000, rd);
            if (rd[`OFS_DONE_BIT] === 1'b1)
                break;
        end
    endtask

    task print_verdict();
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #400us;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        step(8);
        rst_n = 1;
        step(2);
        chk("ch1 code", 16'h000A, {11'h000, ch1_resistor_code});
        rdchk(`ADDR_CH1_RES, 16'h000A, "ch1 reg");
        rdchk(`ADDR_CH2_RES, 16'h000A, "ch2 reg");
        rdchk(`ADDR_CAL_CFG, 16'h0000, "cfg reg");
        rdchk(`ADDR_CMP_OFS, 16'h0000, "ofs reg");
        wr(`ADDR_CH1_RES, 16'h9F15);
        wr(`ADDR_CH2_RES, 16'h0003);
        rdchk(`ADDR_CH1_RES, 16'h8015, "ch1 reg");
        chk("ch1 enable", 16'h0001, {15'h0000, ch1_internal_resistor_enable});
        chk("ch2 enable", 16'h0000, {15'h0000, ch2_internal_resistor_enable});
        chk("codes", 16'h1503, {3'h0, ch1_resistor_code, 3'h0, ch2_resistor_code});
        wr(15'h0010, 16'hFFFF);
        rdchk(15'h0010, 16'h0000, "unmapped");
        // Ones into every read-only flag must not stick.
        wr(`ADDR_CAL_CFG, 16'h7EE9);
        rdchk(`ADDR_CAL_CFG, 16'h0069, "cfg reg");
        chk("range", 16'h0002, {14'h0000, offset_calibration_range});
        cal_cmp_high = 0;
        wr(`ADDR_CMP_OFS, 16'h0001);
        wait_done();
        chk("ofs reg", 16'h7F03, rd);
        rdchk(`ADDR_CAL_CFG, 16'h54E9, "cfg flags");
        rdchk(`ADDR_CH1_RES, 16'h9F15, "ch1 reg");
        chk("codes", 16'h1F1F, {3'h0, ch1_resistor_code, 3'h0, ch2_resistor_code});
        chk("gain", 16'h007F, {9'h000, gain_cal_code});
        chk("offset code", 16'h007F, {9'h000, offset_cal_code});
        wr(`ADDR_CAL_CFG, 16'h0169);
        wr(`ADDR_CAL_CFG, 16'h0069);
        rdchk(`ADDR_CAL_CFG, 16'h0069, "cfg cleared");
        rdchk(`ADDR_CMP_OFS, 16'h0001, "ofs cleared");
        chk("codes", 16'h1503, {3'h0, ch1_resistor_code, 3'h0, ch2_resistor_code});
        chk("gain", 16'h0000, {9'h000, gain_cal_code});
        wr(`ADDR_CMP_OFS, 16'h0000);
        wr(`ADDR_CAL_CFG, 16'h0021);
        cal_cmp_high = 1;
        wr(`ADDR_CMP_OFS, 16'h0001);
        step(100);
        rdchk(`ADDR_CMP_OFS, 16'h0001, "frozen");
        chk("phase", 16'h0001, {13'h0000, cal_phase});
        wr(`ADDR_CAL_CFG, 16'h0029);
        wait_done();
        chk("ofs reg", 16'h0003, rd);
        rdchk(`ADDR_CAL_CFG, 16'h2829, "cfg flags");
        chk("gain", 16'h0000, {9'h000, gain_cal_code});
        chk("codes", 16'h1503, {3'h0, ch1_resistor_code, 3'h0, ch2_resistor_code});
        print_verdict();
    end
endmodule
